// ===== core/apqo_top.v
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "apqo_defs.vh"

module apqo_top #(
    parameter CLK_HZ    = 100000000,
    parameter ANG_BITS  = 15,
    parameter DUTY_BITS = 12
) (
    input  wire                  clk,
    input  wire                  reset,
    input  wire [ANG_BITS-1:0]   angle,
    input  wire [7:0]            reg_addr,
    input  wire [31:0]           reg_wdata,
    input  wire                  reg_wr,
    input  wire                  reg_rd,
    output reg  [31:0]           reg_rdata,
    input  wire                  duty_i,
    output wire                  duty_o,
    output wire                  duty_oe,
    output reg                   enc_a,
    output reg                   enc_b,
    output reg                   enc_i
);

    localparam ACC_W  = 28;
    localparam PROD_W = 40;
    localparam [ACC_W-1:0] CLK_CNT   = CLK_HZ;
    localparam [ACC_W-1:0] EDGE_CNT  = CLK_HZ / `APQO_FULL_PCT * `APQO_EDGE_PCT;
    localparam [PROD_W-1:0] SPAN_CNT = CLK_HZ / `APQO_FULL_PCT * `APQO_SPAN_PCT;

    // configuration rows
    reg [3:0]  carrier_step_select;
    reg [2:0]  carrier_band_select;
    reg [3:0]  res_code;
    reg        enc_invert;

    // duty generator state
    reg [ACC_W-1:0]      phase;
    reg [ACC_W-1:0]      high_cnt;
    reg [DUTY_BITS-1:0]  duty_fraction;
    reg                  duty_level;
    reg                  pin_s1;
    reg                  pin_s2;
    reg [31:0]           period_count;

    wire [11:0]          freq_hz;
    wire [ACC_W-1:0]     phase_sum;
    wire                 period_wrap;
    wire [DUTY_BITS-1:0] angle_duty;
    wire [PROD_W-1:0]    span_prod;
    wire [ACC_W-1:0]     next_high_cnt;

    // encoder state
    reg  [ANG_BITS-1:0]  shifted;
    reg  [1:0]           quad_pos;
    reg                  at_zero;
    wire                 res_ok;
    wire                 next_a;
    wire                 next_b;

    function is_addr;
        input [7:0] addr;
        input [7:0] target;
        begin
            is_addr = (addr == target);
        end
    endfunction

    // register writes
    always @(posedge clk) begin
        if (reset) begin
            carrier_step_select <= `APQO_DUTY_STEP_RESET;
            carrier_band_select <= `APQO_DUTY_BAND_RESET;
            res_code            <= `APQO_ABI_RES_RESET;
            enc_invert          <= `APQO_ABI_INV_RESET;
        end else if (reg_wr) begin
            if (is_addr(reg_addr, `APQO_ADDR_DUTY_ROW)) begin
                carrier_step_select <= reg_wdata[`APQO_DUTY_STEP_MSB:`APQO_DUTY_STEP_LSB];
                carrier_band_select <= reg_wdata[`APQO_DUTY_BAND_MSB:`APQO_DUTY_BAND_LSB];
            end
            if (is_addr(reg_addr, `APQO_ADDR_ABI_ROW)) begin
                res_code   <= reg_wdata[`APQO_ABI_RES_MSB:`APQO_ABI_RES_LSB];
                enc_invert <= reg_wdata[`APQO_ABI_INV_BIT];
            end
        end
    end

    // register reads, answered one cycle after the strobe
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= 32'h0;
            if (is_addr(reg_addr, `APQO_ADDR_DUTY_ROW)) begin
                reg_rdata[`APQO_DUTY_STEP_MSB:`APQO_DUTY_STEP_LSB] <= carrier_step_select;
                reg_rdata[`APQO_DUTY_BAND_MSB:`APQO_DUTY_BAND_LSB] <= carrier_band_select;
            end
            if (is_addr(reg_addr, `APQO_ADDR_ABI_ROW)) begin
                reg_rdata[`APQO_ABI_RES_MSB:`APQO_ABI_RES_LSB] <= res_code;
                reg_rdata[`APQO_ABI_INV_BIT] <= enc_invert;
            end
            if (is_addr(reg_addr, `APQO_ADDR_STATUS)) begin
                reg_rdata[`APQO_ST_A_BIT]      <= enc_a;
                reg_rdata[`APQO_ST_B_BIT]      <= enc_b;
                reg_rdata[`APQO_ST_I_BIT]      <= enc_i;
                reg_rdata[`APQO_ST_PWM_BIT]    <= duty_level;
                reg_rdata[`APQO_ST_PIN_BIT]    <= pin_s2;
                reg_rdata[`APQO_ST_RES_OK_BIT] <= res_ok;
                reg_rdata[`APQO_ST_ANG_MSB:`APQO_ST_ANG_LSB] <= duty_fraction;
            end
            if (is_addr(reg_addr, `APQO_ADDR_PERIODS)) begin
                reg_rdata <= period_count;
            end
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // carrier frequency lookup, one cycle of latency
    apqo_freq_rom u_rom (
        .clk     (clk),
        .band    (carrier_band_select),
        .step    (carrier_step_select),
        .freq_hz (freq_hz)
    );

    // phase accumulator: adding the frequency in Hz each clock and wrapping at
    // the clock rate gives the exact mean period with no divider; edges jitter
    // by at most one clock
    assign phase_sum   = phase + {{(ACC_W-12){1'b0}}, freq_hz};
    assign period_wrap = (phase_sum >= CLK_CNT);

    // duty uses the top 12 bits of the angle word
    assign angle_duty = angle[ANG_BITS-1 -: DUTY_BITS];

    // high time = 5% + 90% * angle / 4096; the largest code gives 4095/4096
    assign span_prod     = SPAN_CNT * {{(PROD_W-DUTY_BITS){1'b0}}, angle_duty};
    assign next_high_cnt = EDGE_CNT + span_prod[DUTY_BITS +: ACC_W];

    always @(posedge clk) begin
        if (reset) begin
            phase         <= {ACC_W{1'b0}};
            high_cnt      <= EDGE_CNT;
            duty_fraction <= {DUTY_BITS{1'b0}};
            period_count  <= 32'h0;
        end else if (period_wrap) begin
            phase         <= phase_sum - CLK_CNT;
            // angle sampled once per period, at its rising edge
            high_cnt      <= next_high_cnt;
            duty_fraction <= angle_duty;
            period_count  <= period_count + 32'h1;
        end else begin
            phase <= phase_sum;
        end
    end

    // high for phase below the threshold; the threshold always lies between
    // 5% and 95% of the period, so both outer margins come out fixed
    always @(posedge clk) begin
        if (reset) begin
            duty_level <= 1'b0;
        end else begin
            duty_level <= (phase < high_cnt);
        end
    end

    // open drain: only ever pulls low, released while high
    assign duty_o  = 1'b0;
    assign duty_oe = ~duty_level;

    // pin readback, for fault checking by software
    always @(posedge clk) begin
        if (reset) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            pin_s1 <= duty_i;
            pin_s2 <= pin_s1;
        end
    end

    // resolution code 3..14 gives N = 14 - code; the lowest kept bit of the
    // angle is bit 13 - N, that is code - 1
    assign res_ok = (res_code >= `APQO_RES_FIRST) && (res_code <= `APQO_RES_LAST);

    always @* begin
        shifted  = angle >> (res_code - 4'h1);
        quad_pos = shifted[1:0];
        at_zero  = (shifted == {ANG_BITS{1'b0}});
    end

    // gray map: 0->00, 1->01, 2->11, 3->10; rising angle walks 0,1,2,3
    assign next_a = quad_pos[1];
    assign next_b = quad_pos[1] ^ quad_pos[0];

    // reserved and undefined codes freeze the pins rather than emit garbage
    always @(posedge clk) begin
        if (reset) begin
            enc_a <= `APQO_ABI_INV_RESET;
            enc_b <= `APQO_ABI_INV_RESET;
            enc_i <= `APQO_ABI_INV_RESET;
        end else if (res_ok) begin
            enc_a <= next_a ^ enc_invert;
            enc_b <= next_b ^ enc_invert;
            enc_i <= at_zero ^ enc_invert;
        end
    end

endmodule // apqo_top

`default_nettype wire

// ===== core/apqo_defs.vh
`ifndef APQO_DEFS_VH
`define APQO_DEFS_VH

// register offsets of the plain register port
`define APQO_ADDR_DUTY_ROW   8'h18
`define APQO_ADDR_ABI_ROW    8'h19
`define APQO_ADDR_STATUS     8'h20
`define APQO_ADDR_PERIODS    8'h21

// duty output setup row fields
`define APQO_DUTY_STEP_LSB   0
`define APQO_DUTY_STEP_MSB   3
`define APQO_DUTY_BAND_LSB   4
`define APQO_DUTY_BAND_MSB   6
`define APQO_DUTY_STEP_RESET 4'h0
`define APQO_DUTY_BAND_RESET 3'h0

// encoder setup row fields
`define APQO_ABI_RES_LSB     0
`define APQO_ABI_RES_MSB     3
`define APQO_ABI_INV_BIT     4
`define APQO_ABI_RES_RESET   4'h4
`define APQO_ABI_INV_RESET   1'h0

// resolution code limits
`define APQO_RES_FIRST       4'h3
`define APQO_RES_LAST        4'he

// status register fields
`define APQO_ST_A_BIT        0
`define APQO_ST_B_BIT        1
`define APQO_ST_I_BIT        2
`define APQO_ST_PWM_BIT      3
`define APQO_ST_PIN_BIT      4
`define APQO_ST_RES_OK_BIT   5
`define APQO_ST_ANG_LSB      16
`define APQO_ST_ANG_MSB      27

// duty figures, in percent of the carrier period
`define APQO_EDGE_PCT        5
`define APQO_SPAN_PCT        90
`define APQO_FULL_PCT        100

// carrier frequency table, Hz, steps 0..15 of each band, step 0 first
`define APQO_B0_LO {12'd3125, 12'd3101, 12'd3077, 12'd3053, 12'd3030, 12'd3008, 12'd2985, 12'd2963}
`define APQO_B0_HI {12'd2941, 12'd2920, 12'd2899, 12'd2878, 12'd2857, 12'd2837, 12'd2817, 12'd2797}
`define APQO_B1_LO {12'd2778, 12'd2740, 12'd2703, 12'd2667, 12'd2632, 12'd2597, 12'd2564, 12'd2532}
`define APQO_B1_HI {12'd2500, 12'd2469, 12'd2439, 12'd2410, 12'd2381, 12'd2353, 12'd2326, 12'd2299}
`define APQO_B2_LO {12'd2273, 12'd2222, 12'd2174, 12'd2128, 12'd2083, 12'd2041, 12'd2000, 12'd1961}
`define APQO_B2_HI {12'd1923, 12'd1887, 12'd1852, 12'd1818, 12'd1786, 12'd1754, 12'd1724, 12'd1695}
`define APQO_B3_LO {12'd1667, 12'd1613, 12'd1563, 12'd1515, 12'd1471, 12'd1429, 12'd1389, 12'd1351}
`define APQO_B3_HI {12'd1316, 12'd1282, 12'd1250, 12'd1220, 12'd1190, 12'd1163, 12'd1136, 12'd1111}
`define APQO_B4_LO {12'd1087, 12'd1042, 12'd1000, 12'd962, 12'd926, 12'd893, 12'd862, 12'd833}
`define APQO_B4_HI {12'd806, 12'd781, 12'd758, 12'd735, 12'd714, 12'd694, 12'd676, 12'd658}
`define APQO_B5_LO {12'd641, 12'd610, 12'd581, 12'd556, 12'd532, 12'd510, 12'd490, 12'd472}
`define APQO_B5_HI {12'd455, 12'd439, 12'd424, 12'd410, 12'd397, 12'd385, 12'd373, 12'd362}
`define APQO_B6_LO {12'd352, 12'd333, 12'd316, 12'd301, 12'd287, 12'd275, 12'd263, 12'd253}
`define APQO_B6_HI {12'd243, 12'd234, 12'd225, 12'd217, 12'd210, 12'd203, 12'd197, 12'd191}
`define APQO_B7_LO {12'd185, 12'd175, 12'd166, 12'd157, 12'd150, 12'd143, 12'd137, 12'd131}
`define APQO_B7_HI {12'd126, 12'd121, 12'd116, 12'd112, 12'd108, 12'd105, 12'd101, 12'd98}

`endif

// ===== core/apqo_freq_rom.v
`timescale 1ns/10ps
`default_nettype none
`include "apqo_defs.vh"

module apqo_freq_rom (
    input  wire        clk,
    input  wire [2:0]  band,
    input  wire [3:0]  step,
    output reg  [11:0] freq_hz
);

    reg [191:0] row;

    always @* begin
        case (band)
            3'h0: row = {`APQO_B0_LO, `APQO_B0_HI};
            3'h1: row = {`APQO_B1_LO, `APQO_B1_HI};
            3'h2: row = {`APQO_B2_LO, `APQO_B2_HI};
            3'h3: row = {`APQO_B3_LO, `APQO_B3_HI};
            3'h4: row = {`APQO_B4_LO, `APQO_B4_HI};
            3'h5: row = {`APQO_B5_LO, `APQO_B5_HI};
            3'h6: row = {`APQO_B6_LO, `APQO_B6_HI};
            3'h7: row = {`APQO_B7_LO, `APQO_B7_HI};
            default: row = {`APQO_B0_LO, `APQO_B0_HI};
        endcase
    end

    // step 0 sits in the top slot of the row
    always @(posedge clk) begin
        freq_hz <= row[(4'hf - step) * 12 +: 12];
    end

endmodule // apqo_freq_rom

`default_nettype wire

// ===== sim/apqo_properties.sv
`timescale 1ns/10ps
`default_nettype none
module apqo_properties #(parameter CLK_HZ = 100000000) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [14:0] angle,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        duty_o,
    input wire logic        duty_oe,
    input wire logic        enc_a,
    input wire logic        enc_b,
    input wire logic        enc_i
);
    // 5% of the shortest carrier period, one clock given away to phase jitter
    localparam int EDGE_MIN = CLK_HZ / 62500 - 1;
    logic [3:0]  code;
    logic        inv;
    logic [1:0]  settle;
    logic [15:0] hi_run;
    logic [15:0] lo_run;
    logic [14:0] s;
    logic        ok;
    logic        qa;
    logic        qb;
    logic        qi;
    assign ok = code >= 4'h3 && code <= 4'he;
    assign s  = angle >> (code - 4'h1);
    assign qa = s[1];
    assign qb = s[1] ^ s[0];
    assign qi = s == 15'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    always_ff @(posedge clk) begin
        if (reset) begin
            code   <= 4'h4;
            inv    <= 1'b0;
            settle <= 2'h0;
            hi_run <= 16'hffff;
            lo_run <= 16'hffff;
        end else begin
            if (reg_wr && reg_addr == 8'h19) begin
                code <= reg_wdata[3:0];
                inv  <= reg_wdata[4];
            end
            // a carrier change lands mid-period and may cut that period short
            if (reg_wr && reg_addr == 8'h18)
                settle <= 2'h3;
            else if ($fell(duty_oe) && settle != 2'h0)
                settle <= settle - 2'h1;
            hi_run <= duty_oe ? 16'h0 : hi_run + 16'(hi_run != 16'hffff);
            lo_run <= !duty_oe ? 16'h0 : lo_run + 16'(lo_run != 16'hffff);
        end
    end
    a_duty_od_low: assert property (duty_o == 1'b0)
        else $error("duty pin driven high");
    a_enc_a_map: assert property (!$past(reset) && $past(ok) |-> enc_a == ($past(qa) ^ $past(inv)))
        else $error("encoder A wrong for angle");
    a_enc_b_map: assert property (!$past(reset) && $past(ok) |-> enc_b == ($past(qb) ^ $past(inv)))
        else $error("encoder B wrong for angle");
    a_index_zero: assert property (!$past(reset) && $past(ok) |-> enc_i == ($past(qi) ^ $past(inv)))
        else $error("index wrong for angle");
    a_res_freeze: assert property (!$past(reset) && !$past(ok) |-> $stable({enc_a, enc_b, enc_i}))
        else $error("encoder moved on reserved code");
    a_res_readback: assert property ($past(reg_rd) && $past(reg_addr) == 8'h19 |-> reg_rdata[4:0] == {$past(inv), $past(code)})
        else $error("encoder row readback wrong");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_high_margin: assert property ($rose(duty_oe) && settle == 2'h0 |-> hi_run >= EDGE_MIN)
        else $error("duty high part too short");
    a_low_margin: assert property ($fell(duty_oe) && settle == 2'h0 |-> lo_run >= EDGE_MIN)
        else $error("duty low part too short");
endmodule // apqo_properties
bind apqo_top apqo_properties #(.CLK_HZ(CLK_HZ)) u_props (.clk, .reset, .angle, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .duty_o, .duty_oe, .enc_a, .enc_b, .enc_i);
`default_nettype wire

// ===== sim/apqo_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module apqo_host_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        duty_oe,
    input  wire logic        duty_o,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic [3:0]  res_code,
    output wire logic        duty_pin,
    output var  logic [13:0] pos,
    output var  logic [7:0]  skips,
    output var  logic [7:0]  rises,
    output var  logic [15:0] meas_high,
    output var  logic [15:0] meas_period
);
    logic [1:0]  g_prev;
    logic [1:0]  d;
    logic [13:0] wrap;
    logic [15:0] hi;
    logic [15:0] per;
    logic        pin_q;
    // pull-up on the wire: a released pin reads high
    assign duty_pin = duty_oe ? duty_o : 1'b1;
    assign d        = {enc_a, enc_a ^ enc_b} - g_prev;
    assign wrap     = 14'h4 << (4'he - res_code);
    always_ff @(posedge clk) begin
        g_prev <= {enc_a, enc_a ^ enc_b};
        pin_q  <= duty_pin;
        if (reset) begin
            pos   <= 14'h0;
            skips <= 8'h0;
            rises <= 8'h0;
            hi    <= 16'h0;
            per   <= 16'h0;
        end else begin
            if (d == 2'h1)
                pos <= (pos + 14'h1) % wrap;
            else if (d == 2'h3)
                pos <= (pos + wrap - 14'h1) % wrap;
            else if (d == 2'h2)
                skips <= skips + 8'h1;
            if (duty_pin && !pin_q) begin
                meas_period <= per;
                meas_high   <= hi;
                per         <= 16'h1;
                hi          <= 16'h1;
                rises       <= rises + 8'h1;
            end else begin
                per <= per + 16'h1;
                hi  <= hi + 16'(duty_pin);
            end
        end
    end
endmodule // apqo_host_model
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // slow phase base keeps a 3125 Hz carrier at 320 clocks
    localparam int HZ = 1000000;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [14:0] angle = 15'h0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [4:0]  abi = 5'h04;
    wire  [31:0] reg_rdata;
    wire         duty_o, duty_oe, enc_a, enc_b, enc_i, duty_pin;
    wire  [13:0] pos;
    wire  [7:0]  skips, rises;
    wire  [15:0] m_hi, m_per;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          p;
    int          h;
    // row: {abi row, angle, expected a b i}
    logic [22:0] er [11] = '{{5'h0e, 15'h0000, 3'b001}, {5'h0e, 15'h2000, 3'b010},
        {5'h0e, 15'h4000, 3'b110}, {5'h0e, 15'h6000, 3'b100}, {5'h1e, 15'h2000, 3'b101},
        {5'h03, 15'h0004, 3'b010}, {5'h03, 15'h000c, 3'b100}, {5'h0d, 15'h3000, 3'b100},
        {5'h1d, 15'h1000, 3'b101}, {5'h02, 15'h4000, 3'b101}, {5'h0f, 15'h0000, 3'b101}};
    // row: {band, step, angle, period in clocks}
    logic [37:0] dr [4] = '{{3'h0, 4'h0, 15'h0000, 16'd320}, {3'h0, 4'h0, 15'h7fff, 16'd320},
        {3'h3, 4'ha, 15'h4000, 16'd800}, {3'h7, 4'hf, 15'h0000, 16'd10204}};
    apqo_top #(.CLK_HZ(HZ)) DUT (.clk, .reset, .angle, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .duty_i(duty_pin), .duty_o, .duty_oe, .enc_a, .enc_b, .enc_i);
    apqo_host_model u_host (.clk, .reset, .duty_oe, .duty_o, .enc_a, .enc_b,
        .res_code(abi[3:0]), .duty_pin, .pos, .skips, .rises, .meas_high(m_hi),
        .meas_period(m_per));
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #900000;
        miscompares++;
        give_verdict;
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        // one turn up, then 100 states back, at the reset resolution, one state per step
        for (int k = 0; k < 4196; k++) begin
            @(posedge clk);
            angle <= (k < 4096) ? angle + 15'h8 : angle - 15'h8;
        end
        repeat (3) @(posedge clk);
        chk(32'(pos), 32'd3996);
        chk(32'(skips), 32'h0);
        $display("sweep done");
        for (int k = 0; k < 11; k++) begin
            abi <= er[k][22:18];
            wr(8'h19, {27'h0, er[k][22:18]});
            angle <= er[k][17:3];
            repeat (2) @(posedge clk);
            #1 chk({29'h0, enc_a, enc_b, enc_i}, {29'h0, er[k][2:0]});
            rd(8'h19, {27'h0, er[k][22:18]});
        end
        $display("encoder table done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h18, {25'h0, dr[k][37:31]});
            angle <= dr[k][30:16];
            repeat (2) @(posedge clk);
            for (int n = 0; n < 3; n++) begin
                h = rises;
                for (int w = 0; w < 12000 && rises == 8'(h); w++) @(posedge clk);
            end
            p = dr[k][15:0];
            h = p * (20480 + 90 * dr[k][30:19]) / 409600;
            chk(32'(m_per >= p - 1 && m_per <= p + 1), 32'h1);
            chk(32'(m_hi >= h - 1 && m_hi <= h + 1), 32'h1);
        end
        $display("duty table done");
        wr(8'h40, 32'h5a);
        rd(8'h40, 32'h0);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({29'h0, enc_a, enc_b, enc_i}, 32'h0);
        @(posedge clk);
        reset <= 1'b0;
        rd(8'h19, 32'h4);
        rd(8'h18, 32'h0);
        $display("reset done");
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
